// *** src/tape_host_control.sv ***
`timescale 1ns/1ns
`default_nettype none
module tape_host_control #(
  parameter int SERVO_UPDATE_CYCLES = tape_ctrl_pkg::SERVO_UPDATE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        link_clk,
  input  wire logic        host_select,
  input  wire logic        host_bit_clock,
  input  wire logic        host_serial_data_in,
  output logic             host_serial_data_out,
  output logic             host_serial_data_oe,
  input  wire logic        transfer_type_lo,
  input  wire logic        transfer_type_hi,
  input  wire logic [7:0]  read_data,
  output logic             read_fetch,
  output logic             read_is_status,
  output logic [1:0]       status_index,
  output logic [5:0]       read_cmd,
  output logic             data_write_strobe,
  output logic [7:0]       data_write_byte,
  output logic [5:0]       data_write_cmd,
  output logic             play_mode,
  output logic             after_record_mode,
  output logic             record_mode,
  output logic             resync_inhibit,
  output logic             label_record,
  output logic             corrected_write_inhibit,
  output logic             portable_tracking,
  output logic             audio_bus_master,
  output logic             port_out_1,
  output logic             port_out_2,
  output logic             port_out_3,
  output logic [1:0]       factory_bits,
  output logic [3:0]       aux_flag_threshold,
  output logic [7:0]       byte_index,
  output logic [6:0]       ram_pointer,
  input  wire logic [7:0]  tape_phase_err,
  input  wire logic [7:0]  tape_rate_dev,
  input  wire logic [7:0]  tape_freq_term,
  output logic             servo_pwm,
  output logic [7:0]       servo_duty_applied
);

  function automatic logic cmd_known(input logic [3:0] nib);
    cmd_known = (nib != 4'h4) && (nib != 4'h7);
  endfunction

  function automatic logic [7:0] abs8(input logic [7:0] v);
    abs8 = v[7] ? 8'(-v) : v;
  endfunction

  // Link domain: pins sampled on link clock
  logic       link_rst_meta;
  logic       link_rst_n;
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic       sel_d;
  logic       bclk_d;
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [5:0] cmd;
  logic [7:0] tx;
  logic [1:0] status_idx;
  logic [7:0] hold_byte;
  logic [5:0] hold_cmd;
  logic       req_tgl;
  tape_ctrl_pkg::xfer_kind_t kind;

  logic       sel_s;
  logic       bclk_s;
  logic       data_s;
  logic [1:0] type_s;
  logic       sel_rise;
  logic       bit_rise;
  logic       byte_done;
  logic [7:0] byte_in;
  logic       kind_read;

  assign sel_s     = pin_sync[4];
  assign bclk_s    = pin_sync[3];
  assign data_s    = pin_sync[2];
  assign type_s    = pin_sync[1:0];
  assign sel_rise  = sel_s && !sel_d;
  assign bit_rise  = sel_s && bclk_s && !bclk_d;
  assign byte_done = bit_rise && (bit_cnt == 3'h7);
  assign byte_in   = {shift_in, data_s};
  assign kind_read = (kind == tape_ctrl_pkg::XK_READ) || (kind == tape_ctrl_pkg::XK_STATUS);

  always_ff @(posedge link_clk) begin
    link_rst_meta <= resetn;
    link_rst_n    <= link_rst_meta;
  end

  always_ff @(posedge link_clk) begin
    pin_meta <= {host_select, host_bit_clock, host_serial_data_in,
                 transfer_type_hi, transfer_type_lo};
    pin_sync <= pin_meta;
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      sel_d  <= 1'b0;
      bclk_d <= 1'b0;
    end else begin
      sel_d  <= sel_s;
      bclk_d <= bclk_s;
    end
  end

  // Transfer kind latched at select rise
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      kind <= tape_ctrl_pkg::XK_IDLE;
    end else if (sel_rise) begin
      case (type_s) // see R23
        tape_ctrl_pkg::XFER_DATA_WRITE: kind <= tape_ctrl_pkg::XK_WRITE;
        tape_ctrl_pkg::XFER_DATA_READ:  kind <= tape_ctrl_pkg::XK_READ;
        tape_ctrl_pkg::XFER_CMD_WRITE:  kind <= tape_ctrl_pkg::XK_CMD;
        default:                        kind <= tape_ctrl_pkg::XK_STATUS;
      endcase
    end else if (!sel_s) begin
      kind <= tape_ctrl_pkg::XK_IDLE;
    end
  end

  // Counter cleared whenever select is low, so a partial byte never leaks
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      bit_cnt  <= 3'h0;
      shift_in <= 7'h00;
    end else if (!sel_s || sel_rise) begin
      bit_cnt  <= 3'h0; // see R22
      shift_in <= 7'h00;
    end else if (bit_rise) begin
      bit_cnt  <= bit_cnt + 3'h1; // see R25
      shift_in <= byte_in[6:0];
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      cmd <= tape_ctrl_pkg::CMD_RESET;
    end else if (byte_done && (kind == tape_ctrl_pkg::XK_CMD)
                 && cmd_known(byte_in[3:0])) begin
      cmd <= byte_in[5:0]; // see R27
    end
  end

  // Held word stays stable a full byte, long enough for the toggle crossing
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      hold_byte <= 8'h00;
      hold_cmd  <= tape_ctrl_pkg::CMD_RESET;
      req_tgl   <= 1'b0;
    end else if (byte_done && (kind == tape_ctrl_pkg::XK_WRITE)) begin
      hold_byte <= byte_in;
      hold_cmd  <= cmd; // see R24
      req_tgl   <= !req_tgl;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      status_idx <= 2'h0;
    end else if (sel_rise) begin
      status_idx <= 2'h0;
    end else if (byte_done && (kind == tape_ctrl_pkg::XK_STATUS)) begin
      status_idx <= status_idx + 2'h1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      read_fetch <= 1'b0;
    end else begin
      read_fetch <= (sel_rise && type_s[0]) || (byte_done && kind_read);
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      tx <= 8'h00;
    end else if (read_fetch) begin
      tx <= read_data;
    end else if (bit_rise) begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      host_serial_data_out <= 1'b0;
      host_serial_data_oe  <= 1'b0;
    end else begin
      host_serial_data_out <= read_fetch ? read_data[7] : (bit_rise ? tx[6] : tx[7]);
      host_serial_data_oe  <= sel_s && kind_read;
    end
  end

  assign read_is_status = (kind == tape_ctrl_pkg::XK_STATUS);
  assign status_index   = status_idx;
  assign read_cmd       = cmd;

  // System domain
  logic [2:0] req_sync;
  logic       req_seen;
  logic [6:0] primary_cfg;
  logic [7:0] secondary_cfg;
  logic [7:0] servo_duty_value;
  tape_ctrl_pkg::op_mode_t mode;
  tape_ctrl_pkg::op_mode_t next_mode;
  logic [3:0] wr_nib;

  assign req_seen = req_sync[2] ^ req_sync[1];
  assign wr_nib   = hold_cmd[3:0];

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      req_sync <= 3'h0;
    end else begin
      req_sync <= {req_sync[1:0], req_tgl};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      primary_cfg        <= tape_ctrl_pkg::PRIMARY_RESET;
      secondary_cfg      <= tape_ctrl_pkg::SECONDARY_RESET;
      aux_flag_threshold <= tape_ctrl_pkg::THRESHOLD_RESET;
      servo_duty_value   <= tape_ctrl_pkg::DUTY_RESET;
      byte_index         <= tape_ctrl_pkg::BYTE_IDX_RESET;
      ram_pointer        <= tape_ctrl_pkg::RAM_PTR_RESET;
    end else if (req_seen) begin
      if (wr_nib == tape_ctrl_pkg::CMD_LOAD_PRIMARY) begin
        primary_cfg <= hold_byte[6:0]; // see R1
      end else if (wr_nib == tape_ctrl_pkg::CMD_LOAD_SECONDARY) begin
        secondary_cfg <= hold_byte; // see R1
      end else if (wr_nib == tape_ctrl_pkg::CMD_LOAD_THRESHOLD) begin
        aux_flag_threshold <= hold_byte[3:0]; // see R2
      end else if (wr_nib == tape_ctrl_pkg::CMD_LOAD_DUTY) begin
        servo_duty_value <= hold_byte; // see R2
      end else if (wr_nib == tape_ctrl_pkg::CMD_LOAD_BYTE_IDX) begin
        byte_index <= hold_byte; // see R3
      end else if (wr_nib == tape_ctrl_pkg::CMD_LOAD_RAM_PTR) begin
        ram_pointer <= hold_byte[6:0]; // see R3
      end
    end
  end

  // Every data write is also offered to the RAM and aux/sysinfo datapaths
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      data_write_strobe <= 1'b0;
      data_write_byte   <= 8'h00;
      data_write_cmd    <= tape_ctrl_pkg::CMD_RESET;
    end else begin
      data_write_strobe <= req_seen;
      if (req_seen) begin
        data_write_byte <= hold_byte;
        data_write_cmd  <= hold_cmd; // see R4 see R5
      end
    end
  end

  always_comb begin
    case (primary_cfg[tape_ctrl_pkg::P_MODE_HI:tape_ctrl_pkg::P_MODE_LO]) // see R21
      tape_ctrl_pkg::MODE_CODE_PLAY:   next_mode = tape_ctrl_pkg::MODE_PLAY;
      tape_ctrl_pkg::MODE_CODE_AFTER:  next_mode = tape_ctrl_pkg::MODE_AFTER;
      tape_ctrl_pkg::MODE_CODE_RECORD: next_mode = tape_ctrl_pkg::MODE_RECORD;
      default:                         next_mode = mode; // see R26
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mode <= tape_ctrl_pkg::MODE_PLAY;
    end else begin
      mode <= next_mode;
    end
  end

  assign play_mode         = (mode == tape_ctrl_pkg::MODE_PLAY);
  assign after_record_mode = (mode == tape_ctrl_pkg::MODE_AFTER);
  assign record_mode       = (mode == tape_ctrl_pkg::MODE_RECORD);

  assign resync_inhibit = primary_cfg[tape_ctrl_pkg::P_NO_RESYNC]; // see R7
  assign corrected_write_inhibit = secondary_cfg[tape_ctrl_pkg::S_NO_CORR]; // see R15
  assign portable_tracking = secondary_cfg[tape_ctrl_pkg::S_PORTABLE]; // see R14
  assign port_out_1 = secondary_cfg[tape_ctrl_pkg::S_PORT1]; // see R12
  assign port_out_2 = secondary_cfg[tape_ctrl_pkg::S_PORT2]; // see R12
  assign port_out_3 = secondary_cfg[tape_ctrl_pkg::S_PORT3]; // see R12
  assign factory_bits = {secondary_cfg[tape_ctrl_pkg::S_FACTORY_B],
                         secondary_cfg[tape_ctrl_pkg::S_FACTORY_A]};

  // Gated by next mode so a gate never lags the mode; host times the label
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      label_record     <= 1'b0;
      audio_bus_master <= tape_ctrl_pkg::SECONDARY_RESET[tape_ctrl_pkg::S_BUS_MASTER];
    end else begin
      label_record     <= primary_cfg[tape_ctrl_pkg::P_LABEL]
                          && (next_mode != tape_ctrl_pkg::MODE_PLAY); // see R8
      audio_bus_master <= secondary_cfg[tape_ctrl_pkg::S_BUS_MASTER]
                          && (next_mode != tape_ctrl_pkg::MODE_RECORD); // see R13
    end
  end

  // Servo duty
  logic        host_servo_control;
  logic        freq_reg_enable;
  logic        ext_freq_reg_enable;
  logic [19:0] upd_cnt;
  logic        upd_tick;
  logic [7:0]  dev_abs;
  logic [7:0]  freq_part;
  logic [7:0]  tape_duty;
  logic [7:0]  pwm_cnt;

  assign host_servo_control  = primary_cfg[tape_ctrl_pkg::P_HOST_SERVO];
  assign freq_reg_enable     = primary_cfg[tape_ctrl_pkg::P_FREQ];
  assign ext_freq_reg_enable = primary_cfg[tape_ctrl_pkg::P_EXT_FREQ];
  assign upd_tick = (upd_cnt == 20'(SERVO_UPDATE_CYCLES - 1));
  assign dev_abs  = abs8(tape_rate_dev);

  always_comb begin
    freq_part = 8'h00;
    if (freq_reg_enable && !record_mode) begin // see R9
      if (dev_abs > tape_ctrl_pkg::DEV_FULL_PERMILLE) begin
        freq_part = tape_freq_term; // see R19
      end else if (ext_freq_reg_enable
                   && (dev_abs > tape_ctrl_pkg::DEV_HALF_PERMILLE)) begin
        freq_part = {tape_freq_term[7], tape_freq_term[7:1]}; // see R10 see R20
      end
    end
  end

  // Eight-bit wrap is deliberate: gives the sawtooth outside the window
  assign tape_duty = tape_ctrl_pkg::DUTY_HALF + tape_phase_err + freq_part; // see R17 see R18

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      upd_cnt <= 20'h00000;
    end else if (upd_tick) begin
      upd_cnt <= 20'h00000;
    end else begin
      upd_cnt <= upd_cnt + 20'h00001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      servo_duty_applied <= tape_ctrl_pkg::DUTY_HALF;
    end else if (host_servo_control) begin
      servo_duty_applied <= servo_duty_value; // see R6
    end else if (record_mode) begin
      servo_duty_applied <= tape_ctrl_pkg::DUTY_HALF;
    end else if (upd_tick) begin
      servo_duty_applied <= tape_duty; // see R16
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pwm_cnt   <= 8'h00;
      servo_pwm <= 1'b0;
    end else begin
      pwm_cnt   <= pwm_cnt + 8'h01;
      servo_pwm <= (pwm_cnt < servo_duty_applied); // see R17
    end
  end

endmodule
`default_nettype wire

// *** src/tape_ctrl_pkg.sv ***
// Notes on behaviour
// R1: Nibble 0000/0001 loads primary/secondary config.
// R2: Nibble 0010 threshold, 0011 servo duty.
// R3: Nibble 0101 byte index, 0110 RAM pointer.
// R4: Nibble 1100/1110 RAM read/write, bits5:4 quarter.
// R5: Nibble 1101/1111 RAM flag+data read/write.
// R6: Host servo control uses programmed duty value.
// R7: Resync inhibit suppresses resynchronisation events.
// R8: Label record only in record/after-record modes.
// R9: Frequency enable mixes frequency into phase.
// R10: Extended frequency needs frequency enable too.
// R11: Host keeps both factory bits at zero.
// R12: Three port bits drive output pins.
// R13: Audio bus master except in record mode.
// R14: Portable tracking bit drives clock extraction.
// R15: Corrected write inhibit blocks DRAM write-back.
// R16: Phase mode recomputes duty every 21.33 ms.
// R17: Phase duty linear, 256 steps, centred.
// R18: Phase characteristic wraps as sawtooth.
// R19: Frequency mixes in beyond 6% deviation.
// R20: Extended: half frequency between 4.5% and 6%.
// R21: Mode bits 00 play, 10 after-record, 11 record.
// R22: Bit counter resets while select low.
// R23: Transfer type 00 wr, 01 rd, 10 cmd, 11 status.
// R24: Data transfers target last command's register.
// R25: Transfers are bytes, narrow registers right-justified.
// R26: Invalid mode code keeps previous mode.
// R27: Unknown command nibble ignored, target kept.
package tape_ctrl_pkg;

  localparam logic [3:0] CMD_AUX_READ       = 4'h8;
  localparam logic [3:0] CMD_SYSINFO_READ   = 4'h9;
  localparam logic [3:0] CMD_AUX_WRITE      = 4'hA;
  localparam logic [3:0] CMD_SYSINFO_WRITE  = 4'hB;
  localparam logic [3:0] CMD_LOAD_PRIMARY   = 4'h0;
  localparam logic [3:0] CMD_LOAD_SECONDARY = 4'h1;
  localparam logic [3:0] CMD_LOAD_THRESHOLD = 4'h2;
  localparam logic [3:0] CMD_LOAD_DUTY      = 4'h3;
  localparam logic [3:0] CMD_LOAD_BYTE_IDX  = 4'h5;
  localparam logic [3:0] CMD_LOAD_RAM_PTR   = 4'h6;
  localparam logic [3:0] CMD_RAM_READ       = 4'hC;
  localparam logic [3:0] CMD_RAM_FLAG_READ  = 4'hD;
  localparam logic [3:0] CMD_RAM_WRITE      = 4'hE;
  localparam logic [3:0] CMD_RAM_FLAG_WRITE = 4'hF;

  localparam logic [1:0] XFER_DATA_WRITE  = 2'h0;
  localparam logic [1:0] XFER_DATA_READ   = 2'h1;
  localparam logic [1:0] XFER_CMD_WRITE   = 2'h2;
  localparam logic [1:0] XFER_STATUS_READ = 2'h3;

  localparam logic [5:0] CMD_RESET       = 6'h00;
  localparam logic [6:0] PRIMARY_RESET   = 7'h00;
  localparam logic [7:0] SECONDARY_RESET = 8'h0C;
  localparam logic [3:0] THRESHOLD_RESET = 4'hA;
  localparam logic [7:0] DUTY_RESET      = 8'h80;
  localparam logic [7:0] BYTE_IDX_RESET  = 8'h00;
  localparam logic [6:0] RAM_PTR_RESET   = 7'h00;

  localparam int P_EXT_FREQ = 6;
  localparam int P_FREQ     = 5;
  localparam int P_LABEL    = 4;
  localparam int P_NO_RESYNC = 3;
  localparam int P_HOST_SERVO = 2;
  localparam int P_MODE_HI  = 1;
  localparam int P_MODE_LO  = 0;
  localparam int S_PORT3    = 7;
  localparam int S_PORT2    = 6;
  localparam int S_FACTORY_B = 5;
  localparam int S_NO_CORR  = 4;
  localparam int S_PORTABLE = 3;
  localparam int S_BUS_MASTER = 2;
  localparam int S_PORT1    = 1;
  localparam int S_FACTORY_A = 0;

  localparam logic [1:0] MODE_CODE_PLAY    = 2'h0;
  localparam logic [1:0] MODE_CODE_INVALID = 2'h1;
  localparam logic [1:0] MODE_CODE_AFTER   = 2'h2;
  localparam logic [1:0] MODE_CODE_RECORD  = 2'h3;

  typedef enum logic [2:0] {
    MODE_PLAY   = 3'h1,
    MODE_AFTER  = 3'h2,
    MODE_RECORD = 3'h4
  } op_mode_t;

  typedef enum logic [4:0] {
    XK_IDLE   = 5'h01,
    XK_WRITE  = 5'h02,
    XK_READ   = 5'h04,
    XK_CMD    = 5'h08,
    XK_STATUS = 5'h10
  } xfer_kind_t;

  localparam int SYS_CLK_KHZ       = 25000;
  localparam int SERVO_UPDATE_US   = 21330;
  localparam int SERVO_UPDATE_CYCLES = (SERVO_UPDATE_US * SYS_CLK_KHZ) / 1000;
  localparam logic [7:0] DUTY_HALF = 8'h80;
  localparam logic [7:0] DEV_FULL_PERMILLE = 8'h3C;
  localparam logic [7:0] DEV_HALF_PERMILLE = 8'h2D;

endpackage

// *** sim/tape_host_control_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module tape_host_control_checker (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       link_clk,
  input wire logic       host_select,
  input wire logic       host_serial_data_oe,
  input wire logic       read_fetch,
  input wire logic [1:0] status_index,
  input wire logic       data_write_strobe,
  input wire logic [7:0] data_write_byte,
  input wire logic [5:0] data_write_cmd,
  input wire logic       play_mode,
  input wire logic       after_record_mode,
  input wire logic       record_mode,
  input wire logic       label_record,
  input wire logic       audio_bus_master
);
  chk_bus_slave: assert property (@(posedge sys_clk) disable iff (!resetn)
    record_mode |-> !audio_bus_master) else $error("bus master in record mode");
  chk_label_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    label_record |-> !play_mode) else $error("label active in play mode");
  chk_mode_onehot: assert property (@(posedge sys_clk) disable iff (!resetn)
    $onehot({record_mode, after_record_mode, play_mode})) else $error("mode not one-hot");
  chk_write_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    data_write_strobe |=> !data_write_strobe) else $error("write strobe too long");
  chk_write_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    ($changed(data_write_byte) || $changed(data_write_cmd)) |-> data_write_strobe)
    else $error("write data changed without strobe");
  // Five cycles cover the two sync flops and the output register
  chk_oe_idle: assert property (@(posedge link_clk) disable iff (!resetn)
    !host_select [*5] |-> !host_serial_data_oe) else $error("data driven while deselected");
  chk_fetch_pulse: assert property (@(posedge link_clk) disable iff (!resetn)
    read_fetch |=> !read_fetch) else $error("fetch pulse too long");
  chk_status_step: assert property (@(posedge link_clk) disable iff (!resetn)
    $changed(status_index) |-> (status_index == 2'h0 || status_index == $past(status_index) + 2'h1))
    else $error("status pointer skipped");
endmodule

bind tape_host_control tape_host_control_checker u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk), .host_select(host_select),
  .host_serial_data_oe(host_serial_data_oe), .read_fetch(read_fetch),
  .status_index(status_index), .data_write_strobe(data_write_strobe),
  .data_write_byte(data_write_byte), .data_write_cmd(data_write_cmd), .play_mode(play_mode),
  .after_record_mode(after_record_mode), .record_mode(record_mode),
  .label_record(label_record), .audio_bus_master(audio_bus_master));
`default_nettype wire

// *** sim/host_link_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
  input  wire logic link_clk,
  input  wire logic line_in,
  output logic      host_select,
  output logic      host_bit_clock,
  output logic      line_drive,
  output logic      transfer_type_lo,
  output logic      transfer_type_hi
);
  initial begin
    host_select = 1'b0;
    host_bit_clock = 1'b0;
    line_drive = 1'b0;
    {transfer_type_hi, transfer_type_lo} = 2'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  task automatic open_frame(input logic [1:0] kind);
    {transfer_type_hi, transfer_type_lo} <= kind;
    tick(2);
    host_select <= 1'b1;
    tick(4);
  endtask
  // Six link cycles a bit: slow, but the pins pass two sync flops
  task automatic shift(input logic [7:0] wr, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      line_drive <= transfer_type_lo ? ~line_drive : wr[7 - i];
      tick(3);
      rd = {rd[6:0], line_in};
      host_bit_clock <= 1'b1;
      tick(3);
      host_bit_clock <= 1'b0;
    end
  endtask
  task automatic close_frame();
    tick(2);
    host_select <= 1'b0;
    tick(5);
  endtask
endmodule
`default_nettype wire

// *** sim/tape_host_control_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHECK(name, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("wrong value %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module tape_host_control_tb;
  logic       sys_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] tape_phase_err = 8'h00, tape_rate_dev = 8'h00, tape_freq_term = 8'h00;
  logic       host_select, host_bit_clock, line_drive, host_line, type_lo, type_hi;
  logic       data_out, data_oe, read_fetch, read_is_status, write_strobe;
  logic [1:0] status_index, factory_bits;
  logic [5:0] read_cmd, write_cmd, last_cmd;
  logic [7:0] read_data, write_byte, last_byte, byte_index, duty;
  logic       play, after, record, resync, label, no_corr, portable, master, p1, p2, p3, pwm;
  logic [3:0] threshold;
  logic [6:0] ram_pointer;
  int         err_count = 0;
  int         cmp_count = 0;
  logic [3:0] codes [8] = '{4'h8, 4'h9, 4'hC, 4'hD, 4'hA, 4'hB, 4'hE, 4'hF};
  logic [1:0] en [7] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h3, 2'h3, 2'h2};
  logic [7:0] dv [7] = '{8'h46, 8'h46, 8'h32, 8'hCE, 8'h1E, 8'h46, 8'h46};

  initial forever #20 sys_clk = ~sys_clk;
  initial begin
    #37;
    forever begin
      link_clk = ~link_clk;
      #80;
    end
  end
  assign host_line = data_oe ? data_out : line_drive;
  assign read_data = read_is_status ? {6'h2A, status_index} : {2'h1, read_cmd};
  always @(posedge sys_clk) begin
    if (write_strobe === 1'b1) begin
      last_byte <= write_byte;
      last_cmd <= write_cmd;
    end
  end

  host_link_model host (.link_clk(link_clk), .line_in(host_line), .host_select(host_select),
    .host_bit_clock(host_bit_clock), .line_drive(line_drive), .transfer_type_lo(type_lo),
    .transfer_type_hi(type_hi));

  tape_host_control #(.SERVO_UPDATE_CYCLES(64)) DUT (.sys_clk(sys_clk), .resetn(resetn),
    .link_clk(link_clk), .host_select(host_select), .host_bit_clock(host_bit_clock),
    .host_serial_data_in(host_line), .host_serial_data_out(data_out),
    .host_serial_data_oe(data_oe), .transfer_type_lo(type_lo), .transfer_type_hi(type_hi),
    .read_data(read_data), .read_fetch(read_fetch), .read_is_status(read_is_status),
    .status_index(status_index), .read_cmd(read_cmd), .data_write_strobe(write_strobe),
    .data_write_byte(write_byte), .data_write_cmd(write_cmd), .play_mode(play),
    .after_record_mode(after), .record_mode(record), .resync_inhibit(resync),
    .label_record(label), .corrected_write_inhibit(no_corr), .portable_tracking(portable),
    .audio_bus_master(master), .port_out_1(p1), .port_out_2(p2), .port_out_3(p3),
    .factory_bits(factory_bits), .aux_flag_threshold(threshold), .byte_index(byte_index),
    .ram_pointer(ram_pointer), .tape_phase_err(tape_phase_err), .tape_rate_dev(tape_rate_dev),
    .tape_freq_term(tape_freq_term), .servo_pwm(pwm), .servo_duty_applied(duty));

  function automatic logic [2:0] next_mode(input logic [1:0] code, input logic [2:0] prev);
    case (code)
      2'h0: next_mode = 3'b001;
      2'h2: next_mode = 3'b010;
      2'h3: next_mode = 3'b100;
      default: next_mode = prev;
    endcase
  endfunction
  function automatic logic [7:0] exp_duty(input logic [1:0] en, input logic [7:0] ph, dev, term);
    logic [7:0] f;
    f = 8'h00;
    if (dev[7]) dev = 8'(-dev); // Deviation counts in either direction
    if (en[0] && dev > tape_ctrl_pkg::DEV_FULL_PERMILLE) f = term;
    else if (en == 2'h3 && dev > tape_ctrl_pkg::DEV_HALF_PERMILLE) f = {term[7], term[7:1]};
    exp_duty = 8'h80 + ph + f;
  endfunction

  task automatic xfer(input logic [1:0] kind, input logic [7:0] wr, output logic [7:0] rd);
    host.open_frame(kind);
    host.shift(wr, 8, rd);
    host.close_frame();
  endtask
  task automatic load(input logic [7:0] cmd, input logic [7:0] val);
    logic [7:0] rd;
    xfer(tape_ctrl_pkg::XFER_CMD_WRITE, cmd, rd);
    xfer(tape_ctrl_pkg::XFER_DATA_WRITE, val, rd);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    complete_run();
  end

  initial begin
    logic [7:0] p, s, v, w, hi, rd, ph, tm;
    logic [2:0] mode;
    logic [8:0] hc;
    void'($urandom(28));
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge link_clk);
    `CHECK("mode", 3'b001, {record, after, play})
    `CHECK("defaults", 2'h3, {portable, master})
    `CHECK("threshold", 4'hA, threshold)
    `CHECK("duty", 8'h80, duty)
    $display("test reset done");
    mode = 3'b001;
    for (int i = 0; i < 16; i++) begin
      p = $urandom;
      p[1:0] = 2'(i * 3);
      s = $urandom & 8'hDE; // Factory bits kept low
      hi = $urandom;
      load({hi[7:4], 4'h0}, p);
      load({hi[3:0], 4'h1}, s);
      mode = next_mode(p[1:0], mode);
      `CHECK("mode", mode, {record, after, play})
      `CHECK("resync", p[3], resync)
      `CHECK("label", p[4] & ~mode[0], label)
      `CHECK("ports", {s[7], s[6], s[1]}, {p3, p2, p1})
      `CHECK("portable", s[3], portable)
      `CHECK("no corr", s[4], no_corr)
      `CHECK("master", s[2] & ~mode[2], master)
      `CHECK("factory", 2'h0, factory_bits)
    end
    $display("test settings done");
    v = $urandom;
    w = $urandom;
    hi = $urandom;
    load({hi[7:4], 4'h2}, v);
    `CHECK("threshold", v[3:0], threshold)
    load({hi[7:4], 4'h5}, v);
    `CHECK("byte index", v, byte_index)
    `CHECK("write byte", v, last_byte)
    load({hi[7:4], 4'h6}, w);
    `CHECK("ram pointer", w[6:0], ram_pointer)
    for (int k = 0; k < 2; k++) begin
      v = $urandom;
      load({hi[7:4], k ? 4'h7 : 4'h4}, v);
      `CHECK("kept cmd", {hi[5:4], 4'h6}, read_cmd)
      `CHECK("kept target", v[6:0], ram_pointer)
    end
    host.open_frame(tape_ctrl_pkg::XFER_CMD_WRITE);
    host.shift(8'hFF, 5, rd);
    host.close_frame();
    load({hi[3:0], 4'h5}, w);
    `CHECK("byte index", w, byte_index)
    $display("test loads done");
    foreach (codes[k]) begin
      hi = $urandom;
      v = $urandom;
      if (k < 4) begin
        xfer(tape_ctrl_pkg::XFER_CMD_WRITE, {hi[7:4], codes[k]}, rd);
        host.open_frame(tape_ctrl_pkg::XFER_DATA_READ);
        for (int j = 0; j < 2; j++) begin
          host.shift(8'h00, 8, rd);
          `CHECK("read byte", {2'h1, hi[5:4], codes[k]}, rd)
        end
        host.close_frame();
      end else begin
        load({hi[7:4], codes[k]}, v);
        `CHECK("write cmd", {hi[5:4], codes[k]}, last_cmd)
        `CHECK("write byte", v, last_byte)
      end
    end
    host.open_frame(tape_ctrl_pkg::XFER_STATUS_READ);
    for (int j = 0; j < 5; j++) begin
      host.shift(8'h00, 8, rd);
      `CHECK("status", {6'h2A, 2'(j)}, rd)
    end
    host.close_frame();
    $display("test access done");
    v = $urandom;
    load(8'h00, 8'h04);
    load(8'h03, v);
    repeat (300) @(posedge sys_clk);
    `CHECK("host duty", v, duty)
    hc = 9'h000;
    repeat (256) begin
      @(posedge sys_clk);
      hc = hc + {8'h00, pwm};
    end
    `CHECK("pwm high", {1'b0, v}, hc)
    load(8'h00, 8'h03);
    repeat (300) @(posedge sys_clk);
    `CHECK("record duty", 8'h80, duty)
    foreach (en[k]) begin
      ph = $urandom;
      tm = $urandom & 8'hFE;
      @(posedge sys_clk);
      tape_phase_err <= ph;
      tape_rate_dev <= dv[k];
      tape_freq_term <= tm;
      load(8'h00, {1'b0, en[k], 5'h00});
      repeat (210) @(posedge sys_clk);
      `CHECK("tape duty", exp_duty(en[k], ph, dv[k], tm), duty)
    end
    $display("test servo done");
    complete_run();
  end
endmodule
`default_nettype wire
